// File: inc/dmec_mem_if.sv
/*
 * Header read port between the check sequencer and the memory reader.
 * Assumes one outstanding read at a time on the core clock.
 */
`timescale 1ns/1ps
interface dmec_mem_if;
    logic        req;
    logic [31:0] addr;
    logic        ack;
    logic [31:0] data;

    modport seq (output req, output addr, input ack, input data);
    modport rdr (input req, input addr, output ack, output data);
endinterface

// File: inc/dmec_pkg.sv
/*
 * Package for the dual-monitor enable check block: register index, field
 * layout, reset values, activation result codes and check-sequencer states.
 * Assumes a single core clock and a register port driven by the core.
 */
// Overview of operation
// - Monitor control register lives at model register index 9BH.
// - Bit 0 is the valid bit; transfer monitor callable only when set.
// - Valid bit clears whenever the logical processor resets.
// - Activation is refused while the valid bit is zero.
// - Virt exit unblocks management interrupts unless bit 2 is set.
// - Certain secure leaf functions clear bit 2.
// - Bits 31:12 hold the 4 KB aligned monitor segment base.
// - Writes setting reserved bits 1, 11:3 or 63:32 fault with code zero.
// - Writes from outside management mode fault with code zero.
// - Writes in exits not ending, or entries not beginning, in management mode fail.
// - Without dual-monitor support any read or write faults with code zero.
// - Reads allowed whenever model reads are, and during any virt exit.
// - Segment header is 32 bytes of 32-bit fields at the base.
// - Features bit 0 selects long mode; bits 31:1 must be zero.
// - Hypervisor call attempts activation only when all entry conditions hold.
// - Structure checks in order: pointer, launch clear, exit controls valid.
// - Nonzero store count needs aligned address and last byte within width.
// - With capability bit 48 set, addresses must not set bits 63:32.
// - First failing structure check skips the rest and fails the call.
// - After structure checks, read base word and compare revision.
// - Long mode bit must be 1 in 64-bit mode, 0 without 64-bit support.
// - Header checks finish before pointer update; failure fails the call.
// - Successful activation causes a management-mode virtualization exit.
package dmec_pkg;

    // ************************************************************
    // Register layout
    // ************************************************************
    localparam logic [31:0] DMEC_MCR_INDEX     = 32'h0000_009b;
    localparam int          DMEC_VALID_BIT     = 0;
    localparam int          DMEC_UNBLOCK_BIT   = 2;
    localparam int          DMEC_BASE_LSB      = 12;
    localparam logic [63:0] DMEC_RSVD_MASK     = 64'hffff_ffff_0000_0ffa;
    localparam logic [63:0] DMEC_MCR_RESET     = 64'h0000_0000_0000_0000;
    localparam logic [63:0] DMEC_BASE_MASK     = 64'h0000_0000_ffff_f000;

    // ************************************************************
    // Header layout and fixed figures
    // ************************************************************
    localparam logic [31:0] DMEC_HDR_REV_OFS   = 32'h0000_0000;
    localparam logic [31:0] DMEC_HDR_FEAT_OFS  = 32'h0000_0004;
    localparam logic [31:0] DMEC_FEAT_RSVD     = 32'hffff_fffe;
    localparam logic [3:0]  DMEC_ALIGN_MASK    = 4'hf;
    localparam int          DMEC_ENTRY_SHIFT   = 4;
    localparam int          DMEC_BASIC_32B_BIT = 48;

    // Check sequencer states
    typedef enum logic [2:0] {
        DMEC_IDLE   = 3'b000,
        DMEC_VIRT_CONTROL_STRUCTURE   = 3'b001,
        DMEC_RD_REV = 3'b010,
        DMEC_RD_FT  = 3'b011,
        DMEC_DONE   = 3'b100
    } dmec_state_e;

    // Result codes of an activation attempt
    typedef enum logic [1:0] {
        DMEC_RES_NONE  = 2'b00,
        DMEC_RES_PASS  = 2'b01,
        DMEC_RES_FAIL  = 2'b10
    } dmec_res_e;

endpackage

// File: rtl/dmec_hdr_reader.sv
/*
 * Header word reader: forwards one read of the monitor segment header
 * to the core memory port and returns the word registered.
 * Assumes the memory port answers with a one-cycle valid pulse.
 */
`timescale 1ns/1ps
module dmec_hdr_reader
    import dmec_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // Sequencer side
    dmec_mem_if.rdr          hdr,
    // Memory side
    output logic             mem_req_o,
    output logic [31:0]      mem_addr_o,
    input  wire logic        mem_vld_i,
    input  wire logic [31:0] mem_data_i
);
    typedef struct packed {
        logic        busy;
        logic        ack;
        logic [31:0] data;
    } dmec_rd_s;

    dmec_rd_s st_r;
    dmec_rd_s st_nxt;

    // Request goes out for one cycle, then wait for the word
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.ack = 1'b0;
        if (!st_r.busy && hdr.req && !st_r.ack)
        begin
            st_nxt.busy = 1'b1;
        end
        else if (st_r.busy && mem_vld_i)
        begin
            st_nxt.busy = 1'b0;
            st_nxt.ack  = 1'b1;
            st_nxt.data = mem_data_i;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign mem_req_o  = !st_r.busy && hdr.req && !st_r.ack;
    assign mem_addr_o = hdr.addr;
    assign hdr.ack    = st_r.ack;
    assign hdr.data   = st_r.data;

    a_rd_ack_once: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        st_r.ack |=> !st_r.ack)
        else $error("Reader ack lasted more than one cycle");
endmodule

// File: rtl/dmec_top.sv
/*
 * Monitor control register and dual-monitor activation checks.
 * Assumes the core presents model register accesses, hypervisor calls and
 * processor mode bits synchronously on CLOCK_I; all inputs are same-domain.
 */
`timescale 1ns/1ps
module dmec_top
    import dmec_pkg::*;
#(
    parameter int PA_WIDTH = 36
)
(
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_B_I,
    // Model register port
    input  wire logic        MR_RD_I,
    input  wire logic        MR_WR_I,
    input  wire logic [31:0] MR_INDEX_I,
    input  wire logic [63:0] MR_WDATA_I,
    input  wire logic        MR_IN_EXIT_I,
    input  wire logic        MR_IN_ENTRY_I,
    input  wire logic        MR_XFER_SMM_I,
    output logic [63:0]      MR_RDATA_O,
    output logic             MR_DONE_O,
    output logic             MR_FAULT_O,
    output logic             MR_WR_FAIL_O,
    // Processor state
    input  wire logic        DUAL_SUPPORT_I,
    input  wire logic        LONG_SUPPORT_I,
    input  wire logic        IN_SMM_I,
    input  wire logic        IN_ROOT_I,
    input  wire logic        V86_OR_COMPAT_I,
    input  wire logic        MODE64_I,
    input  wire logic [1:0]  PRIV_LEVEL_I,
    input  wire logic        DUAL_ACTIVE_I,
    input  wire logic        SECURE_LEAF_CLR_I,
    input  wire logic        VIRT_EXIT_INSTR_I,
    output logic             UNBLOCK_SMI_O,
    // Control structure facts
    input  wire logic        VIRT_CONTROL_STRUCTURE_PTR_VALID_I,
    input  wire logic        VIRT_CONTROL_STRUCTURE_LAUNCHED_I,
    input  wire logic        EXIT_CTLS_OK_I,
    input  wire logic [31:0] STORE_COUNT_I,
    input  wire logic [63:0] STORE_ADDR_I,
    input  wire logic        BASIC_BIT48_I,
    input  wire logic [31:0] REVISION_ID_I,
    // Hypervisor call
    input  wire logic        HCALL_I,
    output logic             HCALL_DONE_O,
    output logic             HCALL_FAIL_O,
    output logic             HCALL_ACTIVATE_O,
    output logic             SMM_EXIT_O,
    // Header memory port
    output logic             MEM_REQ_O,
    output logic [31:0]      MEM_ADDR_O,
    input  wire logic        MEM_VLD_I,
    input  wire logic [31:0] MEM_DATA_I
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [63:0] mcr;
        dmec_state_e state;
        logic [63:0] rdata;
        logic        done;
        logic        fault;
        logic        wr_fail;
        logic        h_done;
        logic        h_fail;
        logic        h_act;
        logic        unblock;
        logic        rd_req;
        logic [31:0] rd_addr;
    } dmec_top_s;

    dmec_top_s st_r;
    dmec_top_s st_nxt;

    dmec_mem_if hdr_bus ();

    // Address within physical width, and optionally within 32 bits
    function automatic logic addr_ok(input logic [67:0] a, input logic lim32);
        logic [67:0] hi_mask;
        hi_mask = ~((68'h1 << PA_WIDTH) - 68'h1);
        addr_ok = ((a & hi_mask) == 68'h0) && !(lim32 && (a[63:32] != 32'h0));
    endfunction

    logic        idx_hit;
    logic        wr_rsvd;
    logic        wr_bad_ctx;
    logic        wr_fails;
    logic        entry_ok;
    logic        virt_control_structure_ok;
    logic        store_ok;
    logic [67:0] last_byte;
    logic [31:0] seg_base;

    // Register decode and write legality
    always_comb
    begin
        idx_hit    = (MR_INDEX_I == DMEC_MCR_INDEX);
        wr_rsvd    = (MR_WDATA_I & DMEC_RSVD_MASK) != 64'h0;
        wr_bad_ctx = !IN_SMM_I;
        wr_fails   = (MR_IN_EXIT_I || MR_IN_ENTRY_I) && !MR_XFER_SMM_I;
        seg_base   = st_r.mcr[31:0] & DMEC_BASE_MASK[31:0];
    end

    // Structure checks in their fixed order, store area bounds
    always_comb
    begin
        last_byte = {4'h0, STORE_ADDR_I}
                    + ({36'h0, STORE_COUNT_I} << DMEC_ENTRY_SHIFT) - 68'h1;
        store_ok  = (STORE_COUNT_I == 32'h0)
                    || (((STORE_ADDR_I[3:0] & DMEC_ALIGN_MASK) == 4'h0)
                        && addr_ok({4'h0, STORE_ADDR_I}, BASIC_BIT48_I)
                        && addr_ok(last_byte, BASIC_BIT48_I));
        virt_control_structure_ok   = VIRT_CONTROL_STRUCTURE_PTR_VALID_I && !VIRT_CONTROL_STRUCTURE_LAUNCHED_I
                    && EXIT_CTLS_OK_I && store_ok;
        entry_ok  = DUAL_SUPPORT_I && IN_ROOT_I && !IN_SMM_I
                    && st_r.mcr[DMEC_VALID_BIT] && !V86_OR_COMPAT_I
                    && (PRIV_LEVEL_I == 2'b00) && !DUAL_ACTIVE_I;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.done    = 1'b0;
        st_nxt.fault   = 1'b0;
        st_nxt.wr_fail = 1'b0;
        st_nxt.h_done  = 1'b0;
        st_nxt.h_fail  = 1'b0;
        st_nxt.h_act   = 1'b0;
        st_nxt.rd_req  = 1'b0;

        // Register reads; reads inside a virt exit are allowed whenever dual-monitor support is present
        if (MR_RD_I && idx_hit)
        begin
            st_nxt.done = 1'b1;
            if (!DUAL_SUPPORT_I)
            begin
                st_nxt.fault = 1'b1;
                st_nxt.rdata = 64'h0;
            end
            else
            begin
                st_nxt.rdata = st_r.mcr & ~DMEC_RSVD_MASK;
            end
        end

        // Register writes; fault beats context failure
        if (MR_WR_I && idx_hit)
        begin
            st_nxt.done = 1'b1;
            if (!DUAL_SUPPORT_I || wr_rsvd || (wr_bad_ctx && !MR_IN_EXIT_I
                && !MR_IN_ENTRY_I))
            begin
                st_nxt.fault = 1'b1;
            end
            else if (wr_fails)
            begin
                st_nxt.wr_fail = 1'b1;
            end
            else
            begin
                st_nxt.mcr = MR_WDATA_I & ~DMEC_RSVD_MASK;
            end
        end

        // Secure leaf clears the unblock control; it wins over a write
        if (SECURE_LEAF_CLR_I)
        begin
            st_nxt.mcr[DMEC_UNBLOCK_BIT] = 1'b0;
        end

        // Virt exit unblocks interrupts unless bit 2 is set, valid ignored
        st_nxt.unblock = VIRT_EXIT_INSTR_I && !st_r.mcr[DMEC_UNBLOCK_BIT];

        // Activation sequencer
        case (st_r.state)
            DMEC_IDLE:
            begin
                if (HCALL_I)
                begin
                    if (entry_ok)
                    begin
                        st_nxt.state = DMEC_VIRT_CONTROL_STRUCTURE;
                    end
                    else
                    begin
                        st_nxt.h_done = 1'b1;
                        st_nxt.h_fail = 1'b1;
                    end
                end
            end
            DMEC_VIRT_CONTROL_STRUCTURE:
            begin
                if (virt_control_structure_ok)
                begin
                    st_nxt.state   = DMEC_RD_REV;
                    st_nxt.rd_req  = 1'b1;
                    st_nxt.rd_addr = seg_base + DMEC_HDR_REV_OFS;
                end
                else
                begin
                    st_nxt.state  = DMEC_IDLE;
                    st_nxt.h_done = 1'b1;
                    st_nxt.h_fail = 1'b1;
                end
            end
            DMEC_RD_REV:
            begin
                st_nxt.rd_req = !hdr_bus.ack;
                if (hdr_bus.ack)
                begin
                    if (hdr_bus.data == REVISION_ID_I)
                    begin
                        st_nxt.state   = DMEC_RD_FT;
                        st_nxt.rd_req  = 1'b1;
                        st_nxt.rd_addr = seg_base + DMEC_HDR_FEAT_OFS;
                    end
                    else
                    begin
                        st_nxt.state  = DMEC_IDLE;
                        st_nxt.h_done = 1'b1;
                        st_nxt.h_fail = 1'b1;
                    end
                end
            end
            DMEC_RD_FT:
            begin
                st_nxt.rd_req = !hdr_bus.ack;
                if (hdr_bus.ack)
                begin
                    st_nxt.state  = DMEC_IDLE;
                    st_nxt.h_done = 1'b1;
                    if (((hdr_bus.data & DMEC_FEAT_RSVD) != 32'h0)
                        || (MODE64_I && !hdr_bus.data[0])
                        || (!LONG_SUPPORT_I && hdr_bus.data[0]))
                    begin
                        st_nxt.h_fail = 1'b1;
                    end
                    else
                    begin
                        st_nxt.h_act = 1'b1;
                    end
                end
            end
            default:
            begin
                st_nxt.state = DMEC_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Reset clears the whole register, valid bit included
    always_ff @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            st_r       <= '0;
            st_r.mcr   <= DMEC_MCR_RESET;
            st_r.state <= DMEC_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign hdr_bus.req  = st_r.rd_req;
    assign hdr_bus.addr = st_r.rd_addr;

    // Header memory reader
    dmec_hdr_reader u_rdr (
        .clk_i      (CLOCK_I),
        .rst_b_i    (RST_B_I),
        .hdr        (hdr_bus),
        .mem_req_o  (MEM_REQ_O),
        .mem_addr_o (MEM_ADDR_O),
        .mem_vld_i  (MEM_VLD_I),
        .mem_data_i (MEM_DATA_I)
    );

    // Outputs come straight from flops
    assign MR_RDATA_O       = st_r.rdata;
    assign MR_DONE_O        = st_r.done;
    assign MR_FAULT_O       = st_r.fault;
    assign MR_WR_FAIL_O     = st_r.wr_fail;
    assign UNBLOCK_SMI_O    = st_r.unblock;
    assign HCALL_DONE_O     = st_r.h_done;
    assign HCALL_FAIL_O     = st_r.h_fail;
    assign HCALL_ACTIVATE_O = st_r.h_act;
    assign SMM_EXIT_O       = st_r.h_act;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);

    a_rsvd_read_zero: assert property ((st_r.mcr & DMEC_RSVD_MASK) == 64'h0)
        else $error("Reserved register bit became set");
    a_rsvd_wr_fault: assert property (MR_WR_I && idx_hit && wr_rsvd
        |=> MR_FAULT_O && $stable(st_r.mcr))
        else $error("Reserved write did not fault");
    a_wr_out_smm: assert property (MR_WR_I && idx_hit && !IN_SMM_I
        && !MR_IN_EXIT_I && !MR_IN_ENTRY_I |=> MR_FAULT_O)
        else $error("Write outside management mode did not fault");
    a_no_support: assert property ((MR_RD_I || MR_WR_I) && idx_hit
        && !DUAL_SUPPORT_I |=> MR_FAULT_O)
        else $error("Access without support did not fault");
    a_invalid_refuse: assert property (HCALL_I && st_r.state == DMEC_IDLE
        && !st_r.mcr[DMEC_VALID_BIT] |=> HCALL_FAIL_O && !HCALL_ACTIVATE_O)
        else $error("Call activated with valid bit clear");
    a_leaf_clear: assert property (SECURE_LEAF_CLR_I
        |=> !st_r.mcr[DMEC_UNBLOCK_BIT])
        else $error("Secure leaf did not clear bit 2");
    a_unblock_gate: assert property (VIRT_EXIT_INSTR_I
        |=> UNBLOCK_SMI_O == !$past(st_r.mcr[DMEC_UNBLOCK_BIT]))
        else $error("Unblock output disagrees with bit 2");
    a_virt_control_structure_fail: assert property (st_r.state == DMEC_VIRT_CONTROL_STRUCTURE && !virt_control_structure_ok
        |=> HCALL_FAIL_O && st_r.state == DMEC_IDLE && !MEM_REQ_O)
        else $error("Structure failure did not end the call");
    a_act_valid: assert property (HCALL_ACTIVATE_O
        |-> st_r.mcr[DMEC_VALID_BIT] && SMM_EXIT_O)
        else $error("Activation without valid bit");

    c_activate: cover property (HCALL_ACTIVATE_O);
    c_rev_fail: cover property (st_r.state == DMEC_RD_REV ##1 HCALL_FAIL_O);
    c_write_ok: cover property (MR_WR_I && idx_hit ##1 !MR_FAULT_O && !MR_WR_FAIL_O);
    c_read: cover property (MR_RD_I && idx_hit && DUAL_SUPPORT_I);
endmodule

// File: verification/tb_dmec_top.sv
/*
 * Self-checking bench for the dual-monitor enable check block: register
 * port, interrupt unblock control and activation checks.
 * Assumes one-cycle register answers and the call timing of the hand-over.
 */
`timescale 1ns/1ps
module tb_dmec_top;

    // ********
    // Stimulus and observed signals
    // ********
    localparam logic [31:0] seg_base = 32'h0012_3000;
    localparam logic [63:0] bad_sa [7] = '{64'h0, 64'h0, 64'h0, 64'h0000_0000_0000_0008,
        64'h0000_0010_0000_0000, 64'h0000_000f_ffff_fff0, 64'h0000_0001_0000_0000};
    localparam logic [63:0] ok_sa [3] = '{64'h0000_000f_ffff_fff0, 64'h0000_0000_0000_0008,
        64'h0000_0001_0000_0000};
    logic        CLOCK_I = 1'b0, RST_B_I = 1'b0, MR_RD_I = 1'b0, MR_WR_I = 1'b0;
    logic [31:0] MR_INDEX_I = 32'h0000_009b;
    logic [63:0] MR_WDATA_I = 64'h0, STORE_ADDR_I, MR_RDATA_O;
    logic        MR_IN_EXIT_I = 1'b0, MR_IN_ENTRY_I = 1'b0, MR_XFER_SMM_I = 1'b0;
    logic        MR_DONE_O, MR_FAULT_O, MR_WR_FAIL_O, UNBLOCK_SMI_O;
    logic        DUAL_SUPPORT_I, LONG_SUPPORT_I, IN_SMM_I, IN_ROOT_I, V86_OR_COMPAT_I;
    logic        MODE64_I, DUAL_ACTIVE_I, SECURE_LEAF_CLR_I = 1'b0, VIRT_EXIT_INSTR_I = 1'b0;
    logic [1:0]  PRIV_LEVEL_I;
    logic        VIRT_CONTROL_STRUCTURE_PTR_VALID_I, VIRT_CONTROL_STRUCTURE_LAUNCHED_I, EXIT_CTLS_OK_I, BASIC_BIT48_I;
    logic [31:0] STORE_COUNT_I, REVISION_ID_I = 32'h0000_0abc, MEM_DATA_I = 32'h0;
    logic        HCALL_I = 1'b0, HCALL_DONE_O, HCALL_FAIL_O, HCALL_ACTIVATE_O, SMM_EXIT_O;
    logic        MEM_REQ_O, MEM_VLD_I = 1'b0;
    logic [31:0] MEM_ADDR_O, hdr_rev, hdr_feat, pdat;
    logic [31:0] rd_addr [2];
    logic [63:0] reg_exp = 64'h0;
    int          fails = 0;
    int          comparisons = 0;
    int          nrd;

    // 25 MHz core clock
    always #20 CLOCK_I = ~CLOCK_I;

    dmec_top #(.PA_WIDTH(36)) u_dmec_top (
        .CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I), .MR_RD_I(MR_RD_I), .MR_WR_I(MR_WR_I),
        .MR_INDEX_I(MR_INDEX_I), .MR_WDATA_I(MR_WDATA_I), .MR_IN_EXIT_I(MR_IN_EXIT_I),
        .MR_IN_ENTRY_I(MR_IN_ENTRY_I), .MR_XFER_SMM_I(MR_XFER_SMM_I),
        .MR_RDATA_O(MR_RDATA_O), .MR_DONE_O(MR_DONE_O), .MR_FAULT_O(MR_FAULT_O),
        .MR_WR_FAIL_O(MR_WR_FAIL_O), .DUAL_SUPPORT_I(DUAL_SUPPORT_I),
        .LONG_SUPPORT_I(LONG_SUPPORT_I), .IN_SMM_I(IN_SMM_I), .IN_ROOT_I(IN_ROOT_I),
        .V86_OR_COMPAT_I(V86_OR_COMPAT_I), .MODE64_I(MODE64_I),
        .PRIV_LEVEL_I(PRIV_LEVEL_I), .DUAL_ACTIVE_I(DUAL_ACTIVE_I),
        .SECURE_LEAF_CLR_I(SECURE_LEAF_CLR_I), .VIRT_EXIT_INSTR_I(VIRT_EXIT_INSTR_I),
        .UNBLOCK_SMI_O(UNBLOCK_SMI_O), .VIRT_CONTROL_STRUCTURE_PTR_VALID_I(VIRT_CONTROL_STRUCTURE_PTR_VALID_I),
        .VIRT_CONTROL_STRUCTURE_LAUNCHED_I(VIRT_CONTROL_STRUCTURE_LAUNCHED_I), .EXIT_CTLS_OK_I(EXIT_CTLS_OK_I),
        .STORE_COUNT_I(STORE_COUNT_I), .STORE_ADDR_I(STORE_ADDR_I),
        .BASIC_BIT48_I(BASIC_BIT48_I), .REVISION_ID_I(REVISION_ID_I), .HCALL_I(HCALL_I),
        .HCALL_DONE_O(HCALL_DONE_O), .HCALL_FAIL_O(HCALL_FAIL_O),
        .HCALL_ACTIVATE_O(HCALL_ACTIVATE_O), .SMM_EXIT_O(SMM_EXIT_O),
        .MEM_REQ_O(MEM_REQ_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_VLD_I(MEM_VLD_I),
        .MEM_DATA_I(MEM_DATA_I));

    // ********
    // Shared tasks
    // ********
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (fails == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Baseline where every activation condition holds
    task automatic good();
        {DUAL_SUPPORT_I, LONG_SUPPORT_I, IN_SMM_I, IN_ROOT_I, V86_OR_COMPAT_I} = 5'b11010;
        {MODE64_I, DUAL_ACTIVE_I, PRIV_LEVEL_I} = 4'b1000;
        {VIRT_CONTROL_STRUCTURE_PTR_VALID_I, VIRT_CONTROL_STRUCTURE_LAUNCHED_I, EXIT_CTLS_OK_I, BASIC_BIT48_I} = 4'b1010;
        {STORE_COUNT_I, STORE_ADDR_I} = 96'h0;
        {hdr_rev, hdr_feat} = {REVISION_ID_I, 32'h0000_0001};
    endtask

    task automatic rst();
        RST_B_I = 1'b0;
        repeat (8) @(posedge CLOCK_I);
        #1;
        RST_B_I = 1'b1;
        reg_exp = 64'h0;
    endtask

    // One register access; ctx is {exit, entry, transfer-in-SYSTEM_MANAGEMENT_MODE}
    task automatic acc(input logic rd, input logic wr, input logic [63:0] d,
                       input logic [2:0] ctx);
        int n;
        // An edge passes first so a strobe never drops and rises in one step
        @(posedge CLOCK_I);
        #1;
        {MR_RD_I, MR_WR_I, MR_WDATA_I} = {rd, wr, d};
        {MR_IN_EXIT_I, MR_IN_ENTRY_I, MR_XFER_SMM_I} = ctx;
        @(posedge CLOCK_I);
        #1;
        {MR_RD_I, MR_WR_I} = 2'b00;
        for (n = 0; n < 4 && MR_DONE_O !== 1'b1; n++)
            @(posedge CLOCK_I) #1;
        if (n == 4)
        begin
            fails++;
            complete_run();
        end
    endtask

    // Write, check the answer flags, then read back the expected image
    task automatic wrc(input logic [63:0] d, input logic [2:0] ctx, input logic ef,
                       input logic ew);
        acc(1'b0, 1'b1, d, ctx);
        chk("write fault", MR_FAULT_O, ef);
        chk("write fail", MR_WR_FAIL_O, ew);
        if (!ef && !ew)
            reg_exp = d & 64'h0000_0000_ffff_f005;
        acc(1'b1, 1'b0, 64'h0, 3'b000);
        chk("read data", MR_RDATA_O, reg_exp);
    endtask

    task automatic pv(input logic exp);
        VIRT_EXIT_INSTR_I = 1'b1;
        @(posedge CLOCK_I);
        #1;
        VIRT_EXIT_INSTR_I = 1'b0;
        chk("unblock", UNBLOCK_SMI_O, exp);
    endtask

    // Call with a memory that answers one cycle after each request
    task automatic hc(input logic ef, input int lat, input int nr);
        int   n;
        logic pend;
        pend = 1'b0;
        nrd = 0;
        @(posedge CLOCK_I);
        #1;
        HCALL_I = 1'b1;
        @(posedge CLOCK_I);
        #1;
        HCALL_I = 1'b0;
        for (n = 1; n < 40 && HCALL_DONE_O !== 1'b1; n++)
        begin
            @(posedge CLOCK_I);
            #1;
            MEM_VLD_I = pend;
            // Idle data toggles so a stale word is never mistaken for an answer
            MEM_DATA_I = pend ? pdat : ~MEM_DATA_I;
            pend = (MEM_REQ_O === 1'b1);
            if (pend)
            begin
                if (nrd < 2)
                    rd_addr[nrd] = MEM_ADDR_O;
                nrd++;
                pdat = (MEM_ADDR_O == seg_base) ? hdr_rev : hdr_feat;
            end
        end
        MEM_VLD_I = 1'b0;
        if (n == 40)
        begin
            fails++;
            complete_run();
        end
        chk("call fail", HCALL_FAIL_O, ef);
        chk("activate", HCALL_ACTIVATE_O, !ef);
        chk("smm exit", SMM_EXIT_O, !ef);
        if (lat != 0)
            chk("latency", n, lat);
        chk("header reads", nrd, nr);
        if (nr > 0)
            chk("revision addr", rd_addr[0], seg_base);
        if (nr > 1)
            chk("features addr", rd_addr[1], seg_base + 32'h4);
    endtask

    // ********
    // Main sequence
    // ********
    initial
    begin
        good();
        IN_SMM_I = 1'b1;
        rst();
        acc(1'b1, 1'b0, 64'h0, 3'b000);
        chk("reset value", MR_RDATA_O, 64'h0);
        wrc(64'h0000_0000_0000_0002, 3'b000, 1'b1, 1'b0);
        wrc(64'h0000_0000_0000_0808, 3'b000, 1'b1, 1'b0);
        wrc(64'h8000_0001_0000_0000, 3'b000, 1'b1, 1'b0);
        IN_SMM_I = 1'b0;
        wrc(64'h0000_0000_0012_3001, 3'b000, 1'b1, 1'b0);
        wrc(64'h0000_0000_0012_3001, 3'b100, 1'b0, 1'b1);
        wrc(64'h0000_0000_0012_3001, 3'b010, 1'b0, 1'b1);
        hc(1'b1, 1, 0);
        IN_SMM_I = 1'b1;
        wrc(64'h0000_0000_0012_3001, 3'b101, 1'b0, 1'b0);
        acc(1'b1, 1'b0, 64'h0, 3'b100);
        chk("exit read", MR_RDATA_O, reg_exp);
        pv(1'b1);
        wrc(64'h0000_0000_0012_3004, 3'b000, 1'b0, 1'b0);
        pv(1'b0);
        SECURE_LEAF_CLR_I = 1'b1;
        @(posedge CLOCK_I);
        #1;
        SECURE_LEAF_CLR_I = 1'b0;
        reg_exp[2] = 1'b0;
        acc(1'b1, 1'b0, 64'h0, 3'b000);
        chk("leaf clear", MR_RDATA_O, reg_exp);
        pv(1'b1);
        wrc(64'h0000_0000_0012_3005, 3'b000, 1'b0, 1'b0);
        DUAL_SUPPORT_I = 1'b0;
        acc(1'b1, 1'b0, 64'h0, 3'b000);
        chk("unsupported read", MR_FAULT_O, 1'b1);
        acc(1'b0, 1'b1, 64'h0, 3'b000);
        chk("unsupported write", MR_FAULT_O, 1'b1);
        good();
        IN_SMM_I = 1'b1;
        wrc(64'h0000_0000_0012_3001, 3'b000, 1'b0, 1'b0);
        // Entry conditions, each broken alone
        for (int i = 0; i < 6; i++)
        begin
            good();
            DUAL_SUPPORT_I = (i != 0);
            IN_ROOT_I = (i != 1);
            IN_SMM_I = (i == 2);
            V86_OR_COMPAT_I = (i == 3);
            PRIV_LEVEL_I = (i == 4) ? 2'h3 : 2'h0;
            DUAL_ACTIVE_I = (i == 5);
            hc(1'b1, 1, 0);
        end
        // Control structure faults, boundary addresses included
        for (int i = 0; i < 7; i++)
        begin
            good();
            VIRT_CONTROL_STRUCTURE_PTR_VALID_I = (i != 0);
            VIRT_CONTROL_STRUCTURE_LAUNCHED_I = (i == 1);
            EXIT_CTLS_OK_I = (i != 2);
            BASIC_BIT48_I = (i == 6);
            STORE_COUNT_I = (i < 3) ? 32'h0 : (i == 5) ? 32'h2 : 32'h1;
            STORE_ADDR_I = bad_sa[i];
            hc(1'b1, 2, 0);
        end
        for (int i = 0; i < 3; i++)
        begin
            good();
            STORE_COUNT_I = (i == 1) ? 32'h0 : 32'h1;
            STORE_ADDR_I = ok_sa[i];
            hc(1'b0, 0, 2);
        end
        // Header revision and feature word cases
        for (int i = 0; i < 5; i++)
        begin
            good();
            MODE64_I = (i < 3);
            LONG_SUPPORT_I = (i != 3);
            hdr_rev = REVISION_ID_I + ((i == 0) ? 32'h1 : 32'h0);
            hdr_feat = (i == 1) ? 32'h3 : (i == 3) ? 32'h1 : 32'h0;
            hc(i != 4, 0, (i == 0) ? 1 : 2);
        end
        good();
        rst();
        acc(1'b1, 1'b0, 64'h0, 3'b000);
        chk("value after reset", MR_RDATA_O, 64'h0);
        hc(1'b1, 1, 0);
        complete_run();
    end

endmodule
